// ==== common/dea_pkg.sv ====
package dea_pkg;
  // bus address of the control/status register
  localparam logic [15:0] DEA_CSR_ADDR = 16'h002c;
  // default base of the 256-byte eeprom window (low byte must be zero)
  localparam logic [15:0] DEA_EEP_BASE = 16'hc000;
  // control/status field positions
  localparam int DEA_BIT_BUSY = 0;
  localparam int DEA_BIT_WMODE = 1;
  localparam int DEA_BIT_IRQ_EN = 2;
  // control/status value after reset
  localparam logic [7:0] DEA_CSR_RST = 8'h00;
  // value of an empty row latch, neutral for the and-merge
  localparam logic [7:0] DEA_LATCH_RST = 8'hff;
  // default length of the internal programming cycle in clock cycles
  localparam int DEA_PROG_CYCLES = 64;
  // number of row latches and row count of the array
  localparam int DEA_ROW_BYTES = 16;
  localparam int DEA_ROWS = 16;
  // programming sequencer states, gray along idle -> program
  typedef enum logic [0:0] {
    DEA_ST_IDLE = 1'b0,
    DEA_ST_PROG = 1'b1
  } dea_state_e;
  // power modes, gray along run -> wait -> halt
  typedef enum logic [1:0] {
    DEA_PM_RUN = 2'b00,
    DEA_PM_WAIT = 2'b01,
    DEA_PM_HALT = 2'b11
  } dea_pm_e;
endpackage

// ==== src/dea_cells.sv ====
`timescale 1ns/1ns
`default_nettype none
// eeprom cell array: asynchronous read, one-cycle row burn of masked latches
module dea_cells #(
  parameter int ROWS = 16,
  parameter int ROW_BYTES = 16
) (
  input wire logic clk_in,
  input wire logic [7:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  input wire logic prog_in,
  input wire logic [3:0] prog_row_in,
  input wire logic [ROW_BYTES-1:0][7:0] prog_data_in,
  input wire logic [ROW_BYTES-1:0] prog_mask_in
);
  // the cells themselves, row-major
  logic [7:0] mem [ROWS*ROW_BYTES];

  // read path is plain combinational, like rom
  assign rd_data_out = mem[rd_addr_in];

  // burn every latched byte of the selected row in one edge
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < ROW_BYTES; i++) begin
      if (prog_in && prog_mask_in[i]) begin
        mem[{prog_row_in, i[3:0]}] <= prog_data_in[i];
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/dea_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
module dea_ctrl
  import dea_pkg::*;
#(
  parameter logic [15:0] EEP_BASE = dea_pkg::DEA_EEP_BASE,
  parameter int PROG_CYCLES = dea_pkg::DEA_PROG_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [15:0] cpu_addr_in,
  input wire logic cpu_rd_in,
  input wire logic cpu_wr_in,
  input wire logic [7:0] cpu_wdata_in,
  input wire logic vector_fetch_in,
  input wire logic wait_for_interrupt_instr_in,
  input wire logic halt_instr_in,
  input wire logic wake_in,
  output logic [7:0] cpu_rdata_out,
  output logic cpu_rdata_oe_out,
  output logic irq_out,
  output logic wait_state_out,
  output logic halt_state_out
);
  import dea_pkg::*;

  // counter width for the programming timer
  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(PROG_CYCLES - 1);

  // the whole state of the block
  typedef struct packed {
    logic irq_en; // completion_irq_en
    logic wmode; // write_mode_sel
    logic busy; // program_start_busy
    dea_state_e st;                    // sequencer state
    dea_pm_e pm;                       // power mode
    logic wait_pend;                   // wait requested while busy
    logic [CW-1:0] cnt;                // programming timer
    logic [3:0] row;                   // target row
    logic [15:0][7:0] ldata;           // row latches
    logic [15:0] lvalid;               // latch written flags
    logic irq;                         // completion request
    logic [7:0] rdata;                 // registered read data
    logic rdata_oe;                    // registered bus drive
    logic wait_st; // flopped wait indication
    logic halt_st; // flopped halt indication
  } dea_reg_s;

  dea_reg_s r_q;
  dea_reg_s r_d;

  // eeprom window decode, shared by read and write paths
  function automatic logic eep_hit(input logic [15:0] a);
    eep_hit = (a[15:8] == EEP_BASE[15:8]);
  endfunction

  // bus qualifiers, only while running
  logic run;
  logic rd_eep;
  logic wr_eep;
  logic rd_csr;
  logic wr_csr;
  logic done;
  logic [7:0] cell_rdata;
  logic [7:0] csr_val;

  assign run = (r_q.pm == DEA_PM_RUN);
  assign rd_eep = run && cpu_rd_in && eep_hit(cpu_addr_in);
  assign wr_eep = run && cpu_wr_in && eep_hit(cpu_addr_in);
  assign rd_csr = run && cpu_rd_in && (cpu_addr_in == DEA_CSR_ADDR);
  assign wr_csr = run && cpu_wr_in && (cpu_addr_in == DEA_CSR_ADDR);
  assign done = (r_q.st == DEA_ST_PROG) && (r_q.cnt == '0) && (r_q.pm != DEA_PM_HALT);

  assign csr_val = {5'h00, r_q.irq_en, r_q.wmode, r_q.busy};

  // cell array, burned on the completion edge
  dea_cells #(
    .ROWS(DEA_ROWS),
    .ROW_BYTES(DEA_ROW_BYTES)
  ) u_cells (
    .clk_in(clk_in),
    .rd_addr_in(cpu_addr_in[7:0]),
    .rd_data_out(cell_rdata),
    .prog_in(done),
    .prog_row_in(r_q.row),
    .prog_data_in(r_q.ldata),
    .prog_mask_in(r_q.lvalid)
  );

  // next-state logic
  always_comb begin
    r_d = r_q;
    r_d.rdata = 8'h00;
    r_d.rdata_oe = 1'b0;
    // rom-like read; reads are data only, no fetch path
    if (rd_eep && !r_q.wmode) begin
      r_d.rdata = cell_rdata;
      r_d.rdata_oe = 1'b1;
    end
    // no eeprom drive in write mode, csr still read; latches have no read path
    if (rd_csr) begin
      r_d.rdata = csr_val;
      r_d.rdata_oe = 1'b1;
    end
    // capture into latch; nothing while read mode
    if (wr_eep && r_q.wmode && !r_q.busy) begin
      r_d.ldata[cpu_addr_in[3:0]] = r_q.ldata[cpu_addr_in[3:0]] & cpu_wdata_in;
      r_d.lvalid[cpu_addr_in[3:0]] = 1'b1;
      // row from last write; software keeps it fixed
      r_d.row = cpu_addr_in[7:4];
    end
    // software access to the control/status register
    if (wr_csr) begin
      r_d.irq_en = cpu_wdata_in[DEA_BIT_IRQ_EN];
      // clear of write mode refused while busy
      if (cpu_wdata_in[DEA_BIT_WMODE] || !r_q.busy) begin
        r_d.wmode = cpu_wdata_in[DEA_BIT_WMODE];
      end
      if (cpu_wdata_in[DEA_BIT_BUSY] && r_d.wmode && !r_q.busy) begin
        // start timed cycle; length from parameter
        r_d.busy = 1'b1;
        r_d.st = DEA_ST_PROG;
        r_d.cnt = CNT_LAST;
      end else if (!cpu_wdata_in[DEA_BIT_BUSY] && r_q.busy) begin
        // software abort, cells left as they are
        r_d.busy = 1'b0;
        r_d.st = DEA_ST_IDLE;
      end
    end
    // timer runs while the program bit is high
    if (r_q.st == DEA_ST_PROG && r_q.cnt != '0 && r_q.pm != DEA_PM_HALT) begin
      r_d.cnt = r_q.cnt - CW'(1);
    end
    if (vector_fetch_in) begin
      r_d.irq = 1'b0;
    end
    // completion clears both bits, irq set wins
    if (done) begin
      r_d.busy = 1'b0;
      r_d.wmode = 1'b0;
      r_d.st = DEA_ST_IDLE;
      if (r_q.irq_en) begin
        r_d.irq = 1'b1;
      end
    end
    // latches cleared at end or write mode falling edge
    if (r_q.wmode && !r_d.wmode) begin
      r_d.ldata = {DEA_ROW_BYTES{DEA_LATCH_RST}};
      r_d.lvalid = '0;
    end
    // power mode handling
    case (r_q.pm)
      DEA_PM_RUN: begin
        // wait now if idle, else after cycle
        if (wait_for_interrupt_instr_in) begin
          // a cycle ending on this edge counts as idle, so no stale pending flag
          if (r_q.st == DEA_ST_IDLE || done) begin
            r_d.pm = DEA_PM_WAIT;
          end else begin
            r_d.wait_pend = 1'b1;
          end
        end
        // pending wait taken once the cycle ends, normally or by software abort
        if (r_q.wait_pend && (done || r_q.st == DEA_ST_IDLE)) begin
          r_d.wait_pend = 1'b0;
          r_d.pm = DEA_PM_WAIT;
        end
      end
      DEA_PM_WAIT: begin
        // leave wait on wake-up
        if (wake_in) begin
          r_d.pm = DEA_PM_RUN;
        end
      end
      DEA_PM_HALT: begin
        // leave halt on wake-up
        if (wake_in) begin
          r_d.pm = DEA_PM_RUN;
        end
      end
      default: begin
        r_d.pm = DEA_PM_RUN;
      end
    endcase
    // halt stops at once, abandons programming
    if (halt_instr_in) begin
      r_d.pm = DEA_PM_HALT;
      r_d.wait_pend = 1'b0;
      r_d.st = DEA_ST_IDLE;
      r_d.busy = 1'b0;
      r_d.wmode = 1'b0;
      r_d.ldata = {DEA_ROW_BYTES{DEA_LATCH_RST}};
      r_d.lvalid = '0;
    end
    // power mode indications registered so the outputs come from flops
    r_d.wait_st = (r_d.pm == DEA_PM_WAIT);
    r_d.halt_st = (r_d.pm == DEA_PM_HALT);
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r_q <= '{irq_en: DEA_CSR_RST[DEA_BIT_IRQ_EN], wmode: DEA_CSR_RST[DEA_BIT_WMODE],
               busy: DEA_CSR_RST[DEA_BIT_BUSY], st: DEA_ST_IDLE, pm: DEA_PM_RUN,
               wait_pend: 1'b0, cnt: '0, row: 4'h0,
               ldata: {DEA_ROW_BYTES{DEA_LATCH_RST}}, lvalid: 16'h0000,
               irq: 1'b0, rdata: 8'h00, rdata_oe: 1'b0, wait_st: 1'b0, halt_st: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from flops
  assign cpu_rdata_out = r_q.rdata;
  assign cpu_rdata_oe_out = r_q.rdata_oe;
  assign irq_out = r_q.irq;
  assign wait_state_out = r_q.wait_st;
  assign halt_state_out = r_q.halt_st;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence rd_ok_s;
    rd_eep && !r_q.wmode;
  endsequence
  sequence drive_s;
    cpu_rdata_oe_out && cpu_rdata_out == $past(cell_rdata);
  endsequence

  rom_read_a: assert property (rd_ok_s |=> drive_s) else $error("eeprom read not served");
  read_block_a: assert property (rd_eep && r_q.wmode && !rd_csr |=> !cpu_rdata_oe_out)
    else $error("bus driven in write mode");
  write_ignore_a: assert property (wr_eep && !r_q.wmode && !halt_instr_in |=> $stable(r_q.lvalid))
    else $error("write captured in read mode");
  latch_and_a: assert property (wr_eep && r_q.wmode && !r_q.busy && !halt_instr_in
    |=> r_q.ldata[$past(cpu_addr_in[3:0])] == ($past(r_q.ldata[cpu_addr_in[3:0]]) & $past(cpu_wdata_in)))
    else $error("latch not and-merged");
  done_clear_a: assert property (done |=> !r_q.busy && !r_q.wmode && r_q.lvalid == 16'h0000)
    else $error("completion did not clear");
  irq_set_a: assert property (done && r_q.irq_en |=> irq_out)
    else $error("completion irq missing");
  irq_hold_a: assert property (irq_out && !vector_fetch_in |=> irq_out)
    else $error("irq dropped early");
  irq_clr_a: assert property (irq_out && vector_fetch_in && !done |=> !irq_out)
    else $error("irq not cleared by vector fetch");
  wmode_keep_a: assert property (wr_csr && r_q.busy && !cpu_wdata_in[DEA_BIT_WMODE] && !halt_instr_in
    && !done |=> r_q.wmode) else $error("write mode cleared while busy");
  prog_len_a: assert property ($rose(r_q.busy) |-> r_q.cnt == CNT_LAST)
    else $error("timer not loaded");
  csr_read_a: assert property (rd_csr |=> cpu_rdata_out[7:3] == 5'h00 && cpu_rdata_oe_out)
    else $error("reserved csr bits nonzero");
  wait_now_a: assert property (wait_for_interrupt_instr_in && run && r_q.st == DEA_ST_IDLE
    && !halt_instr_in |=> wait_state_out) else $error("wait not entered");
  halt_now_a: assert property (halt_instr_in |=> halt_state_out && !r_q.busy)
    else $error("halt not immediate");
endmodule
`default_nettype wire

// ==== testbench/dea_cpu.sv ====
`timescale 1ns/1ns
`default_nettype none
// cpu bus master model: one access at a time, signals change just after an edge
module dea_cpu (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic oe_in,
  output logic [15:0] addr_out,
  output logic rd_out,
  output logic wr_out,
  output logic [7:0] wdata_out,
  output logic [3:0] evt_out
);
  // bus idle at time zero
  initial begin
    addr_out = 16'h0000;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    evt_out = 4'h0;
  end
  // row held constant
  // callers keep addr[7:4] fixed between burns; released data shows its inverse
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask
  // data reads only
  // answer taken at the edge after the one that took the read
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic oe);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    @(posedge clk_in);
    d = rdata_in;
    oe = oe_in;
  endtask
  // no mid-cycle abort
  // one-cycle pulse: 0 vector fetch, 1 wait, 2 halt, 3 wake
  task automatic pulse(input int k);
    @(posedge clk_in);
    evt_out[k] <= 1'b1;
    @(posedge clk_in);
    evt_out[k] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
// bench: csr layout, refused accesses, burn with irq, wait and halt
module tb;
  import dea_pkg::*;
  // short programming cycle keeps the run brief
  localparam int PC = 16;
  localparam logic [15:0] B = DEA_EEP_BASE;
  localparam logic [15:0] C = DEA_CSR_ADDR;
  logic clk_in;
  logic rst_n_in;
  logic [15:0] addr;
  logic rd, wr, oe, irq, wst, hst, o;
  logic [7:0] wd, rdat, d;
  logic [3:0] evt;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  dea_cpu dea_cpu_i (.clk_in(clk_in), .rdata_in(rdat), .oe_in(oe), .addr_out(addr), .rd_out(rd),
    .wr_out(wr), .wdata_out(wd), .evt_out(evt));
  dea_ctrl #(.PROG_CYCLES(PC)) dea_ctrl_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .cpu_addr_in(addr),
    .cpu_rd_in(rd), .cpu_wr_in(wr), .cpu_wdata_in(wd), .vector_fetch_in(evt[0]),
    .wait_for_interrupt_instr_in(evt[1]), .halt_instr_in(evt[2]), .wake_in(evt[3]),
    .cpu_rdata_out(rdat), .cpu_rdata_oe_out(oe), .irq_out(irq), .wait_state_out(wst), .halt_state_out(hst));
  // one comparison, counted
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // read and compare drive enable, and data when driven
  task automatic rchk(input string n, input logic [15:0] a, input logic [7:0] e, input logic eo);
    dea_cpu_i.rd(a, d, o);
    chk(n, {7'h00, eo}, {7'h00, o});
    if (eo) chk(n, e, d);
  endtask
  // poll status until the busy bit drops, bounded
  task automatic wait_done();
    int n;
    n = 0;
    d = 8'h01;
    while (d[DEA_BIT_BUSY] !== 1'b0 && n < 10) begin
      dea_cpu_i.rd(C, d, o);
      n++;
    end
    // a poll limit that runs out counts as a mismatch
    chk("busy drop", 8'h00, {7'h00, d[DEA_BIT_BUSY]});
  endtask
  // counts, verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // 50 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      stop_test();
    end
  end
  // main sequence
  initial begin
    rst_n_in = 1'b0;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rchk("csr reset", C, DEA_CSR_RST, 1'b1);
    dea_cpu_i.wr(B + 16'h0035, 8'haa);
    dea_cpu_i.wr(C, 8'hfe);
    rchk("csr fields", C, 8'h06, 1'b1);
    $display("test csr done");
    rchk("read in write mode", B + 16'h0035, 8'h00, 1'b0);
    dea_cpu_i.wr(B + 16'h0035, 8'hf0);
    dea_cpu_i.wr(B + 16'h0035, 8'h3c);
    dea_cpu_i.wr(B + 16'h0034, 8'h81);
    dea_cpu_i.wr(C, 8'h07);
    rchk("busy", C, 8'h07, 1'b1);
    dea_cpu_i.wr(C, 8'h05);
    rchk("mode kept", C, 8'h07, 1'b1);
    wait_done();
    rchk("csr done", C, 8'h04, 1'b1);
    chk("irq set", 8'h01, {7'h00, irq});
    dea_cpu_i.pulse(0);
    @(posedge clk_in);
    #1 chk("irq cleared", 8'h00, {7'h00, irq});
    rchk("cell 35", B + 16'h0035, 8'h30, 1'b1);
    rchk("cell 34", B + 16'h0034, 8'h81, 1'b1);
    $display("test burn done");
    dea_cpu_i.wr(C, 8'h02);
    dea_cpu_i.wr(B + 16'h0036, 8'h5a);
    dea_cpu_i.wr(C, 8'h03);
    dea_cpu_i.pulse(1);
    #1 chk("wait deferred", 8'h00, {7'h00, wst});
    repeat (PC + 4) @(posedge clk_in);
    #1 chk("wait entered", 8'h01, {7'h00, wst});
    chk("irq disabled", 8'h00, {7'h00, irq});
    dea_cpu_i.pulse(3);
    rchk("cell 36", B + 16'h0036, 8'h5a, 1'b1);
    rchk("cell 35 kept", B + 16'h0035, 8'h30, 1'b1);
    $display("test wait done");
    dea_cpu_i.wr(C, 8'h02);
    dea_cpu_i.wr(B + 16'h0037, 8'h00);
    dea_cpu_i.wr(C, 8'h03);
    dea_cpu_i.pulse(2);
    #1 chk("halt entered", 8'h01, {7'h00, hst});
    dea_cpu_i.pulse(3);
    rchk("csr after halt", C, 8'h00, 1'b1);
    // wait instruction while idle: wait at once, bus ignored until wake
    dea_cpu_i.pulse(1);
    #1 chk("wait at once", 8'h01, {7'h00, wst});
    rchk("csr in wait", C, 8'h00, 1'b0);
    dea_cpu_i.pulse(3);
    #1 chk("wait left", 8'h00, {7'h00, wst});
    $display("test halt done");
    stop_test();
  end
endmodule
`default_nettype wire
